//--- design/adcsq_pkg.sv
package adcsq_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADCSQ_UFLAG_OFS = 8'h20; // underflow flags
  localparam logic [7:0] ADCSQ_PRIO_OFS = 8'h28; // sequencer priority
  localparam logic [7:0] ADCSQ_INIT_OFS = 8'h2c; // initial control

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int ADCSQ_NSEQ = 4; // number of sequencers
  localparam int ADCSQ_PRIO_STRIDE = 4; // bit distance between priority fields
  localparam logic [31:0] ADCSQ_PRIO_RST = 32'h0000_3210; // 0,1,2,3
  localparam logic [31:0] ADCSQ_PRIO_MASK = 32'h0000_3333; // writable bits
  localparam logic [31:0] ADCSQ_INIT_MASK = 32'h0000_f0ff; // writable bits
  localparam logic [31:0] ADCSQ_INIT_RST = 32'h0000_0000;
  localparam logic [3:0] ADCSQ_UFLAG_RST = 4'h0;
  localparam logic [1:0] ADCSQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] ADCSQ_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // result fifo side of one converter: empty flags and read requests
  typedef struct packed {
    logic [3:0] empty; // fifo holds no entries
    logic [3:0] rd_req; // one-cycle read request
  } adcsq_fifo_t;

  // sequencer choice
  typedef struct packed {
    logic valid; // some sequencer chosen
    logic [1:0] idx; // chosen sequencer
  } adcsq_pick_t;

endpackage

//--- design/adcsq_prio_pick.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// priority picker: lowest field value among pending wins
// ------------------------------------------------------------------
module adcsq_prio_pick
  import adcsq_pkg::*;
(
  input wire logic [3:0] pend_in,
  input wire logic [31:0] prio_in,
  output adcsq_pick_t pick_out
);

  // scan all sequencers, keep smallest priority value; ties keep lower index
  always_comb
  begin
    logic [1:0] best;
    logic [1:0] cur;
    best = 2'h3;
    pick_out = '0;
    cur = 2'h0;
    for (int i = 0; i < ADCSQ_NSEQ; i++)
    begin
      cur = prio_in[i*ADCSQ_PRIO_STRIDE +: 2];
      if (pend_in[i] && (!pick_out.valid || cur < best))
      begin
        best = cur;
        pick_out.valid = 1'b1;
        pick_out.idx = 2'(i);
      end
    end
  end

endmodule

//--- design/adcsq_top.sv
`timescale 1ns/1ps
module adcsq_top
  import adcsq_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  // axi4-lite write address
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [7:0] S_AXI_AWADDR_IN,
  // axi4-lite write data
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  // axi4-lite write response
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  output logic [1:0] S_AXI_BRESP_OUT,
  // axi4-lite read address
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  input wire logic [7:0] S_AXI_ARADDR_IN,
  // axi4-lite read data
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  // result fifo side
  input wire adcsq_fifo_t FIFO_IN,
  output logic [3:0] FIFO_POP_OUT, // pointer advance, only when not empty
  output logic [3:0] FIFO_ZERO_OUT, // read in the previous cycle found the fifo empty and returned zeros
  // sequencer scheduling
  input wire logic [3:0] SEQ_PEND_IN,
  output adcsq_pick_t SEQ_PICK_OUT,
  output logic [31:0] INIT_CTRL_OUT // initial control bits to the converter
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic aw_got_ff, nxt_aw_got; // write address held
  logic w_got_ff, nxt_w_got; // write data held
  logic [7:0] aw_addr_ff, nxt_aw_addr;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [3:0] uflag_ff, nxt_uflag; // underflow flags
  logic [31:0] prio_ff, nxt_prio; // priority register
  logic [31:0] init_ff, nxt_init; // initial control register
  logic [3:0] pop_ff, nxt_pop;
  logic [3:0] zero_ff, nxt_zero;
  logic awready_ff, nxt_awready; // write address slot free
  logic wready_ff, nxt_wready; // write data slot free
  logic arready_ff, nxt_arready; // read slot free
  adcsq_pick_t pick_ff;
  adcsq_pick_t pick_c; // combinational choice
  logic do_wr; // write commits this cycle
  logic [31:0] wmask; // byte-lane mask

  // ----------------------------------------------------------------
  // priority choice
  // ----------------------------------------------------------------
  adcsq_prio_pick u_pick (
    .pend_in(SEQ_PEND_IN),
    .prio_in(prio_ff),
    .pick_out(pick_c)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // bus slave, registers and fifo underflow tracking
  always_comb
  begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    nxt_uflag = uflag_ff;
    nxt_prio = prio_ff;
    nxt_init = init_ff;
    wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
    // capture address and data in either order
    if (S_AXI_AWVALID_IN && !aw_got_ff)
    begin
      nxt_aw_got = 1'b1;
      nxt_aw_addr = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && !w_got_ff)
    begin
      nxt_w_got = 1'b1;
      nxt_w_data = S_AXI_WDATA_IN;
      nxt_w_strb = S_AXI_WSTRB_IN;
    end
    do_wr = aw_got_ff && w_got_ff && !bvalid_ff;
    if (do_wr)
    begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = ADCSQ_RESP_OKAY;
      case (aw_addr_ff)
        ADCSQ_UFLAG_OFS: nxt_uflag = uflag_ff & ~(w_data_ff[3:0] & wmask[3:0]);
        ADCSQ_PRIO_OFS: nxt_prio = (prio_ff & ~(wmask & ADCSQ_PRIO_MASK))
                                   | (w_data_ff & wmask & ADCSQ_PRIO_MASK);
        ADCSQ_INIT_OFS: nxt_init = (init_ff & ~(wmask & ADCSQ_INIT_MASK))
                                   | (w_data_ff & wmask & ADCSQ_INIT_MASK);
        default: nxt_bresp = ADCSQ_RESP_SLVERR;
      endcase
    end
    if (bvalid_ff && S_AXI_BREADY_IN)
      nxt_bvalid = 1'b0;
    // reads answer one cycle after the address is taken
    if (S_AXI_ARVALID_IN && !rvalid_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = ADCSQ_RESP_OKAY;
      case (S_AXI_ARADDR_IN)
        ADCSQ_UFLAG_OFS: nxt_rdata = {28'h0000000, uflag_ff};
        ADCSQ_PRIO_OFS: nxt_rdata = prio_ff;
        ADCSQ_INIT_OFS: nxt_rdata = init_ff;
        default:
        begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = ADCSQ_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff && S_AXI_RREADY_IN)
      nxt_rvalid = 1'b0;
    // empty read sets flag; set wins over clear
    nxt_uflag = nxt_uflag | (FIFO_IN.rd_req & FIFO_IN.empty);
    nxt_pop = FIFO_IN.rd_req & ~FIFO_IN.empty;
    nxt_zero = FIFO_IN.rd_req & FIFO_IN.empty;
    // readies registered so bus outputs come straight from flops
    nxt_awready = !nxt_aw_got;
    nxt_wready = !nxt_w_got;
    nxt_arready = !nxt_rvalid;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= ADCSQ_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= ADCSQ_RESP_OKAY;
      uflag_ff <= ADCSQ_UFLAG_RST;
      prio_ff <= ADCSQ_PRIO_RST;
      init_ff <= ADCSQ_INIT_RST;
      pop_ff <= 4'h0;
      zero_ff <= 4'h0;
      // slots free while in reset
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      arready_ff <= 1'b1;
      pick_ff <= '0;
    end
    else
    begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      aw_addr_ff <= nxt_aw_addr;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      uflag_ff <= nxt_uflag;
      prio_ff <= nxt_prio;
      init_ff <= nxt_init;
      pop_ff <= nxt_pop;
      zero_ff <= nxt_zero;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      arready_ff <= nxt_arready;
      pick_ff <= pick_c;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign S_AXI_AWREADY_OUT = awready_ff;
  assign S_AXI_WREADY_OUT = wready_ff;
  assign S_AXI_BVALID_OUT = bvalid_ff;
  assign S_AXI_BRESP_OUT = bresp_ff;
  assign S_AXI_ARREADY_OUT = arready_ff;
  assign S_AXI_RVALID_OUT = rvalid_ff;
  assign S_AXI_RDATA_OUT = rdata_ff;
  assign S_AXI_RRESP_OUT = rresp_ff;
  assign FIFO_POP_OUT = pop_ff;
  assign FIFO_ZERO_OUT = zero_ff;
  assign SEQ_PICK_OUT = pick_ff;
  assign INIT_CTRL_OUT = init_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);

  uflag_set_a: assert property (
    (FIFO_IN.rd_req[0] && FIFO_IN.empty[0]) |=> uflag_ff[0])
    else $error("empty read did not set flag");
  empty_nopop_a: assert property (
    (FIFO_IN.rd_req[1] && FIFO_IN.empty[1]) |=> (!FIFO_POP_OUT[1] && FIFO_ZERO_OUT[1]))
    else $error("empty read moved pointer");
  w1c_clear_a: assert property (
    (do_wr && aw_addr_ff == ADCSQ_UFLAG_OFS && w_data_ff[2] && w_strb_ff[0]
     && !(FIFO_IN.rd_req[2] && FIFO_IN.empty[2])) |=> !uflag_ff[2])
    else $error("write one did not clear flag");
  w0_keep_a: assert property (
    (uflag_ff[3] && !(do_wr && w_data_ff[3])) |=> uflag_ff[3])
    else $error("flag lost without write one");
  uflag_read_a: assert property (
    (S_AXI_ARVALID_IN && !rvalid_ff && S_AXI_ARADDR_IN == ADCSQ_UFLAG_OFS)
    |=> (S_AXI_RDATA_OUT[31:4] == 28'h0000000 && S_AXI_RDATA_OUT[3:0] == $past(uflag_ff)))
    else $error("flag read wrong");
  prio_resv_a: assert property (
    (prio_ff & ~ADCSQ_PRIO_MASK) == 32'h0000_0000)
    else $error("priority reserved bit set");
  uf_prop_a: assert property (
    (FIFO_IN.rd_req[2] && FIFO_IN.empty[2]) |=> uflag_ff[2])
    else $error("seq two underflow missing");
  prio_write_a: assert property (
    (do_wr && aw_addr_ff == ADCSQ_PRIO_OFS && w_strb_ff[0])
    |=> (prio_ff[1:0] == $past(w_data_ff[1:0])))
    else $error("priority field not written");
  pick_order_a: assert property (
    (SEQ_PEND_IN == 4'h3 && prio_ff[5:4] < prio_ff[1:0]) |=> (SEQ_PICK_OUT.idx == 2'h1))
    else $error("priority order wrong");
  bresp_hold_a: assert property (
    (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN) |=> S_AXI_BVALID_OUT)
    else $error("write response dropped");

  wr_cov_c: cover property (do_wr && aw_addr_ff == ADCSQ_PRIO_OFS);
  uf_cov_c: cover property (FIFO_IN.rd_req[0] && FIFO_IN.empty[0]);
  clr_cov_c: cover property (do_wr && aw_addr_ff == ADCSQ_UFLAG_OFS);
  pick_cov_c: cover property (SEQ_PEND_IN == 4'hf);

endmodule

//--- dv/adcsq_tb.sv
`timescale 1ns/1ps
// compare two values, count it, report a mismatch at once
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module testbench
  import adcsq_pkg::*;
;
  // ------------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------------
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, init_ctrl, rd_word;
  logic [3:0] wstrb, pend, pop, zero;
  logic [1:0] bresp, rresp, resp;
  adcsq_fifo_t fifo;
  adcsq_pick_t pick;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  adcsq_top adcsq_top_inst (.CLOCK_IN(clk), .RST_IN(rst),
    .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_AWADDR_IN(awaddr),
    .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(wstrb), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .FIFO_IN(fifo), .FIFO_POP_OUT(pop),
    .FIFO_ZERO_OUT(zero), .SEQ_PEND_IN(pend), .SEQ_PICK_OUT(pick), .INIT_CTRL_OUT(init_ctrl));
  // ------------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // a hang ends the run with a counted mismatch
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      results();
    end
  end
  // ------------------------------------------------------------------
  // bus tasks: hold each channel until its handshake edge
  // ------------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    // let an edge pass so a previous release is not overridden
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_read(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        rd_word = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // one fifo read request, outputs judged one cycle later
  task automatic fifo_read(input int n, input logic is_empty);
    @(posedge clk);
    fifo.empty <= is_empty ? (4'h1 << n) : 4'h0;
    fifo.rd_req <= 4'h1 << n;
    @(posedge clk);
    fifo.rd_req <= 4'h0;
    #1;
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic test_reset_values();
    axi_read(ADCSQ_PRIO_OFS);
    `CHK(rd_word, 32'h0000_3210)
    axi_read(ADCSQ_UFLAG_OFS);
    `CHK(rd_word, 32'h0000_0000)
    $display("test reset values done");
  endtask
  // every sequencer flags an empty read, keeps pointers, zeroes data
  task automatic test_underflow();
    for (int n = 0; n < 4; n++)
    begin
      fifo_read(n, 1'b0);
      `CHK(pop, 4'h1 << n)
      axi_read(ADCSQ_UFLAG_OFS);
      `CHK(rd_word, 32'h0000_0000)
      fifo_read(n, 1'b1);
      `CHK(zero, 4'h1 << n)
      `CHK(pop, 4'h0)
      axi_read(ADCSQ_UFLAG_OFS);
      `CHK(rd_word[3:0], 4'h1 << n)
      axi_write(ADCSQ_UFLAG_OFS, 32'h0000_0000);
      axi_read(ADCSQ_UFLAG_OFS);
      `CHK(rd_word, 32'h1 << n)
      axi_write(ADCSQ_UFLAG_OFS, 32'hffff_ffff);
      axi_read(ADCSQ_UFLAG_OFS);
      `CHK(rd_word, 32'h0000_0000)
    end
    $display("test underflow done");
  endtask
  // reserved bits stay zero, writable masks hold
  task automatic test_reserved();
    axi_write(ADCSQ_PRIO_OFS, 32'hffff_cdef);
    axi_read(ADCSQ_PRIO_OFS);
    `CHK(rd_word, 32'h0000_0123)
    axi_write(ADCSQ_INIT_OFS, 32'hffff_ffff);
    axi_read(ADCSQ_INIT_OFS);
    `CHK(rd_word, 32'h0000_f0ff)
    `CHK(init_ctrl, 32'h0000_f0ff)
    axi_read(8'h24);
    `CHK(resp, ADCSQ_RESP_SLVERR)
    `CHK(rd_word, 32'h0000_0000)
    axi_write(8'h24, 32'h0000_0001);
    `CHK(resp, ADCSQ_RESP_SLVERR)
    $display("test reserved done");
  endtask
  // reversed priorities decide which pending sequencer goes first
  task automatic test_priority();
    axi_write(ADCSQ_PRIO_OFS, 32'h0000_0123);
    `CHK(resp, ADCSQ_RESP_OKAY)
    @(posedge clk);
    pend <= 4'hf;
    @(posedge clk);
    #1;
    `CHK(pick, {1'b1, 2'h3})
    @(posedge clk);
    pend <= 4'h3;
    @(posedge clk);
    #1;
    `CHK(pick, {1'b1, 2'h1})
    @(posedge clk);
    pend <= 4'h0;
    @(posedge clk);
    #1;
    `CHK(pick.valid, 1'b0)
    wstrb <= 4'h1;
    axi_write(ADCSQ_PRIO_OFS, 32'hffff_ff32);
    wstrb <= 4'hf;
    axi_read(ADCSQ_PRIO_OFS);
    `CHK(rd_word, 32'h0000_0132)
    $display("test priority done");
  endtask
  // ------------------------------------------------------------------
  // closing report
  // ------------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    pend = 4'h0;
    fifo = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    test_reset_values();
    test_underflow();
    test_reserved();
    test_priority();
    results();
  end
endmodule
